// *** ppc_defines.svh ***
// Constants for the port pin configuration and data block.
// Assumes a 32-bit classic Wishbone register bus and an 8-pin port.
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// ==========================================
// Widths
`define PPC_PINS        8
`define PPC_ADR_W       8
`define PPC_DAT_W       32

// ==========================================
// Register byte offsets
`define PPC_OFF_DATA    8'h00
`define PPC_OFF_DIR     8'h04
`define PPC_OFF_RDR     8'h08
`define PPC_OFF_PE      8'h0C
`define PPC_OFF_PS      8'h10
`define PPC_OFF_IE      8'h14
`define PPC_OFF_STAT    8'h18
`define PPC_OFF_MASK    8'h1C
`define PPC_OFF_PIN     8'h20
`define PPC_OFF_EFFDIR  8'h24

// ==========================================
// Reset values and fixed settings
`define PPC_RST_BYTE    8'h00
`define PPC_RST_WORD    32'h0000_0000
`define PPC_PS_ONES     8'hFF
`define PPC_PS_ZEROS    8'h00

// ==========================================
// Alternate function bit positions on the first port
`define PPC_BIT_WKUP    3
`define PPC_BIT_NMI     1
`define PPC_BIT_MIRQ    0

`endif

// *** ppc_edge.sv ***
// Edge detector with sticky status bits cleared by a read pulse.
// Assumes synchronised levels on the same clock.
`timescale 1ns/10ps
`include "ppc_defines.svh"

module ppc_edge #(
	parameter int WIDTH = `PPC_PINS
) (
	input  wire logic             i_clock,
	input  wire logic             i_srst,
	input  wire logic [WIDTH-1:0] i_level,
	input  wire logic [WIDTH-1:0] i_enable,
	input  wire logic [WIDTH-1:0] i_rising,
	input  wire logic [WIDTH-1:0] i_clear,
	output logic      [WIDTH-1:0] o_status
);

	logic [WIDTH-1:0] prev_r;
	logic             primed_r;
	logic [WIDTH-1:0] status_r;
	logic [WIDTH-1:0] status_nxt;
	logic [WIDTH-1:0] rise_w;
	logic [WIDTH-1:0] fall_w;
	logic [WIDTH-1:0] event_w;

	// ==========================================
	// Edge selection
	assign rise_w     = i_level & ~prev_r;
	assign fall_w     = ~i_level & prev_r;
	assign event_w    = {WIDTH{primed_r}} & i_enable
	                  & ((i_rising & rise_w) | (~i_rising & fall_w));
	assign status_nxt = (status_r & ~i_clear) | event_w;

	// ==========================================
	// State
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			prev_r   <= '0;
			primed_r <= 1'b0;
			status_r <= '0;
		end else begin
			prev_r   <= i_level;
			primed_r <= 1'b1;
			status_r <= status_nxt;
		end
	end

	assign o_status = status_r;

endmodule : ppc_edge

// *** ppc_pins.sv ***
// External pin model: pads, outside drivers and pulls resolved per pin.
// Assumes pad controls from ppc_top; undriven, unpulled pins wander.
`timescale 1ns/10ps

module ppc_pins (
	input  wire logic              i_clock,
	input  wire ppc_pkg::ppc_pad_t i_pad,
	input  wire logic [7:0]        i_ext,
	input  wire logic [7:0]        i_ext_en,
	output logic      [7:0]        o_pin
);
	import ppc_pkg::*;
	logic [7:0] float_r = 8'h55;
	always_ff @(posedge i_clock) begin
		float_r <= ~o_pin;
	end
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			if (i_pad.seg_sel[k] || i_pad.oe[k]) o_pin[k] = i_pad.out[k];
			else if (i_ext_en[k]) o_pin[k] = i_ext[k];
			else if (i_pad.pull_up[k]) o_pin[k] = 1'b1;
			else if (i_pad.pull_down[k]) o_pin[k] = 1'b0;
			else o_pin[k] = float_r[k];
		end
	end
endmodule : ppc_pins

// *** ppc_pkg.sv ***
// Types shared by the port pin configuration and data block.
// Assumes ppc_defines.svh is on the include path.
`include "ppc_defines.svh"

package ppc_pkg;

	// ==========================================
	// Port kinds
	typedef enum {
		PPC_KIND_FIRST,
		PPC_KIND_ANALOG,
		PPC_KIND_INTR,
		PPC_KIND_PLAIN
	} ppc_kind_t;

	// ==========================================
	// Alternate function controls from peripherals
	typedef struct packed {
		logic [`PPC_PINS-1:0] seg_en;
		logic [`PPC_PINS-1:0] seg_out;
		logic                 wkup_clk_en;
		logic                 wkup_clk_out;
		logic                 nmi_en;
		logic                 mirq_en;
	} ppc_alt_t;

	// ==========================================
	// Pad controls toward the pins
	typedef struct packed {
		logic [`PPC_PINS-1:0] out;
		logic [`PPC_PINS-1:0] oe;
		logic [`PPC_PINS-1:0] reduced;
		logic [`PPC_PINS-1:0] pull_up;
		logic [`PPC_PINS-1:0] pull_down;
		logic [`PPC_PINS-1:0] in_en;
		logic [`PPC_PINS-1:0] seg_sel;
	} ppc_pad_t;

endpackage : ppc_pkg

// *** ppc_sync.sv ***
// Two-flop synchroniser for the pin inputs.
// Assumes one clock; inputs arrive from outside its domain.
`timescale 1ns/10ps
`include "ppc_defines.svh"

module ppc_sync #(
	parameter int WIDTH = `PPC_PINS
) (
	input  wire logic             i_clock,
	input  wire logic             i_srst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// ==========================================
	// Two stages
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule : ppc_sync

// *** ppc_top.sv ***
// Port pin configuration and data block with a Wishbone register slave.
// Assumes one 100 MHz clock, synchronous reset, pins with external pads.
`timescale 1ns/10ps
`include "ppc_defines.svh"

module ppc_top
	import ppc_pkg::*;
#(
	parameter ppc_pkg::ppc_kind_t KIND = ppc_pkg::PPC_KIND_FIRST
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_srst,
	input  wire logic                   i_wb_cyc,
	input  wire logic                   i_wb_stb,
	input  wire logic                   i_wb_we,
	input  wire logic [`PPC_ADR_W-1:0]  i_wb_adr,
	input  wire logic [3:0]             i_wb_sel,
	input  wire logic [`PPC_DAT_W-1:0]  i_wb_dat,
	output logic      [`PPC_DAT_W-1:0]  o_wb_dat,
	output logic                        o_wb_ack,
	input  wire logic [`PPC_PINS-1:0]   i_pin,
	input  wire ppc_pkg::ppc_alt_t      i_alt,
	output ppc_pkg::ppc_pad_t           o_pad,
	output logic                        o_nmi_req,
	output logic                        o_mirq_req,
	output logic                        o_irq
);

	import ppc_pkg::*;

	localparam int  W        = `PPC_PINS;
	localparam bit  IS_FIRST = (KIND == PPC_KIND_FIRST);
	localparam bit  HAS_IRQ  = (KIND == PPC_KIND_INTR) || (KIND == PPC_KIND_ANALOG);

	// ==========================================
	// Software registers
	logic [W-1:0]            data_r;
	logic [W-1:0]            dir_r;
	logic [W-1:0]            rdr_r;
	logic [W-1:0]            pe_r;
	logic [W-1:0]            ps_r;
	logic [W-1:0]            ie_r;
	logic [W-1:0]            mask_r;

	// ==========================================
	// Bus state
	logic                    ack_r;
	logic [`PPC_DAT_W-1:0]   rdat_r;
	logic [`PPC_DAT_W-1:0]   rdat_nxt;

	// ==========================================
	// Pad and status outputs
	ppc_pad_t                pad_r;
	ppc_pad_t                pad_nxt;
	logic                    irq_r;
	logic                    nmi_req_r;
	logic                    mirq_req_r;

	// ==========================================
	// Internal nets
	logic [W-1:0]            pin_sync;
	logic [W-1:0]            status;
	logic [W-1:0]            ps_eff;
	logic [W-1:0]            ie_eff;
	logic [W-1:0]            eff_dir;
	logic [W-1:0]            data_view;
	logic                    bus_req;
	logic                    fire;
	logic                    wr_fire;
	logic                    rd_fire;
	logic                    wr_lane0;
	logic [W-1:0]            wr_byte;
	logic                    hit_data;
	logic                    hit_dir;
	logic                    hit_rdr;
	logic                    hit_pe;
	logic                    hit_ps;
	logic                    hit_ie;
	logic                    hit_stat;
	logic                    hit_mask;
	logic                    hit_pin;
	logic                    hit_effdir;
	logic                    stat_clear;
	logic [W-1:0]            stat_seen_r;
	logic [W-1:0]            stat_clr_mask;

	// ==========================================
	// Pin input synchroniser
	ppc_sync #(
		.WIDTH   (W)
	) u_sync (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_async (i_pin),
		.o_sync  (pin_sync)
	);

	// ==========================================
	// Bus handshake
	assign bus_req  = i_wb_cyc & i_wb_stb;
	assign fire     = bus_req & ack_r;
	assign wr_fire  = fire & i_wb_we;
	assign rd_fire  = fire & ~i_wb_we;
	assign wr_lane0 = wr_fire & i_wb_sel[0];
	assign wr_byte  = i_wb_dat[W-1:0];

	// ==========================================
	// Address decode
	assign hit_data   = (i_wb_adr == `PPC_OFF_DATA);
	assign hit_dir    = (i_wb_adr == `PPC_OFF_DIR);
	assign hit_rdr    = (i_wb_adr == `PPC_OFF_RDR);
	assign hit_pe     = (i_wb_adr == `PPC_OFF_PE);
	assign hit_ps     = (i_wb_adr == `PPC_OFF_PS);
	assign hit_ie     = (i_wb_adr == `PPC_OFF_IE);
	assign hit_stat   = (i_wb_adr == `PPC_OFF_STAT);
	assign hit_mask   = (i_wb_adr == `PPC_OFF_MASK);
	assign hit_pin    = (i_wb_adr == `PPC_OFF_PIN);
	assign hit_effdir = (i_wb_adr == `PPC_OFF_EFFDIR);
	assign stat_clear = rd_fire & hit_stat;
	assign stat_clr_mask = {W{stat_clear}} & stat_seen_r;

	// ==========================================
	// Fixed or selectable pull and edge select
	assign ps_eff = IS_FIRST ? `PPC_PS_ONES :
	                (KIND == PPC_KIND_ANALOG) ? `PPC_PS_ZEROS : ps_r;
	assign ie_eff = HAS_IRQ ? ie_r : `PPC_RST_BYTE;

	// ==========================================
	// Data read source
	assign data_view = (dir_r & data_r) | (~dir_r & pin_sync);

	// ==========================================
	// Per-pin pad control
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_pin
			logic seg;
			logic force_out;
			logic force_in;
			logic dir_bit;
			logic out_bit;

			assign seg       = i_alt.seg_en[gi];
			assign force_out = IS_FIRST && (gi == `PPC_BIT_WKUP)
			                 && i_alt.wkup_clk_en;
			assign force_in  = IS_FIRST
			                 && (((gi == `PPC_BIT_NMI) && i_alt.nmi_en)
			                 || ((gi == `PPC_BIT_MIRQ) && i_alt.mirq_en));
			assign dir_bit   = seg       ? 1'b0 :
			                   force_out ? 1'b1 :
			                   force_in  ? 1'b0 :
			                   dir_r[gi];
			assign out_bit   = seg       ? i_alt.seg_out[gi] :
			                   force_out ? i_alt.wkup_clk_out :
			                   data_r[gi];

			assign eff_dir[gi]           = dir_bit;
			assign pad_nxt.out[gi]       = out_bit;
			assign pad_nxt.oe[gi]        = dir_bit & ~seg;
			assign pad_nxt.reduced[gi]   = dir_bit & ~seg & rdr_r[gi];
			assign pad_nxt.pull_up[gi]   = ~dir_bit & ~seg & pe_r[gi]
			                             & ~ps_eff[gi];
			assign pad_nxt.pull_down[gi] = ~dir_bit & ~seg & pe_r[gi]
			                             & ps_eff[gi];
			assign pad_nxt.in_en[gi]     = ~seg;
			assign pad_nxt.seg_sel[gi]   = seg;
		end
	endgenerate

	// ==========================================
	// Edge interrupt status
	generate
		if (HAS_IRQ) begin : g_irq
			ppc_edge #(
				.WIDTH    (W)
			) u_edge (
				.i_clock  (i_clock),
				.i_srst   (i_srst),
				.i_level  (pin_sync),
				.i_enable (ie_eff),
				.i_rising (ps_eff),
				.i_clear  (stat_clr_mask),
				.o_status (status)
			);
		end else begin : g_no_irq
			assign status = `PPC_RST_BYTE;
		end
	endgenerate

	// ==========================================
	// Read data mux
	always_comb begin
		rdat_nxt = `PPC_RST_WORD;
		if (hit_data) begin
			rdat_nxt[W-1:0] = data_view;
		end else if (hit_dir) begin
			rdat_nxt[W-1:0] = dir_r;
		end else if (hit_rdr) begin
			rdat_nxt[W-1:0] = rdr_r;
		end else if (hit_pe) begin
			rdat_nxt[W-1:0] = pe_r;
		end else if (hit_ps) begin
			rdat_nxt[W-1:0] = ps_eff;
		end else if (hit_ie) begin
			rdat_nxt[W-1:0] = ie_eff;
		end else if (hit_stat) begin
			rdat_nxt[W-1:0] = status;
		end else if (hit_mask) begin
			rdat_nxt[W-1:0] = mask_r;
		end else if (hit_pin) begin
			rdat_nxt[W-1:0] = pin_sync;
		end else if (hit_effdir) begin
			rdat_nxt[W-1:0] = eff_dir;
		end
	end

	// ==========================================
	// Bus acknowledge and registered read data
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ack_r  <= 1'b0;
			rdat_r <= `PPC_RST_WORD;
		end else begin
			ack_r  <= bus_req & ~ack_r;
			if (bus_req & ~ack_r) begin
				rdat_r <= rdat_nxt;
			end
		end
	end

	// ==========================================
	// Status bits reported by the read in flight
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			stat_seen_r <= `PPC_RST_BYTE;
		end else if (bus_req & ~ack_r) begin
			stat_seen_r <= status;
		end
	end

	// ==========================================
	// Data and direction registers
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			data_r <= `PPC_RST_BYTE;
			dir_r  <= `PPC_RST_BYTE;
		end else begin
			if (wr_lane0 & hit_data) begin
				data_r <= wr_byte;
			end
			if (wr_lane0 & hit_dir) begin
				dir_r <= wr_byte;
			end
		end
	end

	// ==========================================
	// Drive and pull registers
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			rdr_r <= `PPC_RST_BYTE;
			pe_r  <= `PPC_RST_BYTE;
			ps_r  <= `PPC_RST_BYTE;
		end else begin
			if (wr_lane0 & hit_rdr) begin
				rdr_r <= wr_byte;
			end
			if (wr_lane0 & hit_pe) begin
				pe_r <= wr_byte;
			end
			if (wr_lane0 & hit_ps) begin
				ps_r <= wr_byte;
			end
		end
	end

	// ==========================================
	// Interrupt enable and mask registers
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ie_r   <= `PPC_RST_BYTE;
			mask_r <= `PPC_RST_BYTE;
		end else begin
			if (wr_lane0 & hit_ie) begin
				ie_r <= wr_byte;
			end
			if (wr_lane0 & hit_mask) begin
				mask_r <= wr_byte;
			end
		end
	end

	// ==========================================
	// Registered pad, request and interrupt outputs
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pad_r      <= '0;
			irq_r      <= 1'b0;
			nmi_req_r  <= 1'b0;
			mirq_req_r <= 1'b0;
		end else begin
			pad_r      <= pad_nxt;
			irq_r      <= |(status & mask_r);
			nmi_req_r  <= IS_FIRST & i_alt.nmi_en
			            & pin_sync[`PPC_BIT_NMI];
			mirq_req_r <= IS_FIRST & i_alt.mirq_en
			            & pin_sync[`PPC_BIT_MIRQ];
		end
	end

	// ==========================================
	// Output assignments
	assign o_wb_ack   = ack_r;
	assign o_wb_dat   = rdat_r;
	assign o_pad      = pad_r;
	assign o_irq      = irq_r;
	assign o_nmi_req  = nmi_req_r;
	assign o_mirq_req = mirq_req_r;

endmodule : ppc_top

// *** ppc_top_chk.sv ***
// Assertion checker for ppc_top, bound to every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`include "ppc_defines.svh"

module ppc_top_chk #(
	parameter ppc_pkg::ppc_kind_t KIND = ppc_pkg::PPC_KIND_FIRST
) (
	input wire logic                  i_clock,
	input wire logic                  i_srst,
	input wire logic                  i_wb_cyc,
	input wire logic                  i_wb_stb,
	input wire logic [`PPC_DAT_W-1:0] o_wb_dat,
	input wire logic                  o_wb_ack,
	input wire ppc_pkg::ppc_alt_t     i_alt,
	input wire ppc_pkg::ppc_pad_t     o_pad,
	input wire logic                  o_nmi_req,
	input wire logic                  o_mirq_req,
	input wire logic                  o_irq
);
	import ppc_pkg::*;
	// ==========================================
	// Helpers
	logic       first;
	logic       no_irq;
	logic [1:0] rst_q;
	logic       settled;
	assign first = (KIND == PPC_KIND_FIRST);
	assign no_irq = first || (KIND == PPC_KIND_PLAIN);
	assign settled = (rst_q == 2'h0);
	always_ff @(posedge i_clock) begin
		rst_q <= {rst_q[0], i_srst};
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// ==========================================
	// Properties
	ack_one_shot_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held too long");
	ack_next_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("ack missing");
	rd_upper_zero_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	seg_owns_pin_a: assert property (settled |-> o_pad.seg_sel == $past(i_alt.seg_en)
		&& ((o_pad.oe | o_pad.in_en) & $past(i_alt.seg_en)) == 8'h00
		&& ((o_pad.out ^ $past(i_alt.seg_out)) & $past(i_alt.seg_en)) == 8'h00)
		else $error("segment does not own pin");
	pull_exclusive_a: assert property (((o_pad.pull_up | o_pad.pull_down)
		& (o_pad.oe | o_pad.seg_sel)) == 8'h00 && (o_pad.pull_up & o_pad.pull_down) == 8'h00)
		else $error("pull device active wrongly");
	ps_fixed_a: assert property (first |-> o_pad.pull_up == 8'h00)
		else $error("pull up on fixed select port");
	wkup_drives_a: assert property (settled && first
		&& $past(i_alt.wkup_clk_en && !i_alt.seg_en[3])
		|-> o_pad.oe[3] && o_pad.out[3] == $past(i_alt.wkup_clk_out))
		else $error("wakeup clock not driven");
	nmi_input_a: assert property (settled && first
		&& $past(i_alt.nmi_en && !i_alt.seg_en[1]) |-> !o_pad.oe[1] && o_pad.in_en[1])
		else $error("nonmaskable pin not input");
	mirq_input_a: assert property (settled && first
		&& $past(i_alt.mirq_en && !i_alt.seg_en[0]) |-> !o_pad.oe[0] && o_pad.in_en[0])
		else $error("maskable pin not input");
	req_gated_a: assert property ((o_nmi_req |-> $past(i_alt.nmi_en))
		and (o_mirq_req |-> $past(i_alt.mirq_en)))
		else $error("request without enable");
	no_edge_irq_a: assert property (no_irq |-> !o_irq)
		else $error("interrupt on port without edges");
endmodule : ppc_top_chk

bind ppc_top ppc_top_chk #(.KIND(KIND)) ppc_top_chk_i (.i_clock(i_clock), .i_srst(i_srst),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.i_alt(i_alt), .o_pad(o_pad), .o_nmi_req(o_nmi_req), .o_mirq_req(o_mirq_req),
	.o_irq(o_irq));

// *** ppc_top_test.sv ***
// Self-checking bench for ppc_top: first-port and edge-interrupt instances.
// Assumes both share the bus; pins come from ppc_pins models.
`timescale 1ns/10ps
`include "ppc_defines.svh"
`define CHK(NM, E, G) begin n_compared++; if ((G) !== (E)) begin n_fail++; \
	$display("Error %s expected %h seen %h", NM, E, G); end end

module ppc_top_test;
	import ppc_pkg::*;
	int          n_fail = 0;
	int          n_compared = 0;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, which = 1'b0;
	logic [7:0]  wb_adr = 8'h00, ext = 8'h00, ext_en = 8'h00, pin1, pin2, tmp;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000, rd1, rd2;
	logic        ack1, ack2, nmi1, mirq1, irq1, irq2;
	ppc_alt_t    alt = '0;
	ppc_pad_t    pad1, pad2;
	always #5 clock = ~clock;
	// ==========================================
	// Instances
	ppc_top ppc_top_i (.i_clock(clock), .i_srst(srst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
		.i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat),
		.o_wb_dat(rd1), .o_wb_ack(ack1), .i_pin(pin1), .i_alt(alt), .o_pad(pad1),
		.o_nmi_req(nmi1), .o_mirq_req(mirq1), .o_irq(irq1));
	ppc_top #(.KIND(PPC_KIND_INTR)) ppc_top_i_irq (.i_clock(clock), .i_srst(srst),
		.i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
		.i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_dat(rd2), .o_wb_ack(ack2), .i_pin(pin2),
		.i_alt(alt), .o_pad(pad2), .o_nmi_req(), .o_mirq_req(), .o_irq(irq2));
	ppc_pins ppc_pins_i (.i_clock(clock), .i_pad(pad1), .i_ext(ext), .i_ext_en(ext_en),
		.o_pin(pin1));
	ppc_pins ppc_pins_i2 (.i_clock(clock), .i_pad(pad2), .i_ext(ext), .i_ext_en(ext_en),
		.o_pin(pin2));
	// ==========================================
	// Bus tasks
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt
	task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
		output logic [7:0] rd);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hF;
		wb_dat <= {24'h00_0000, wd};
		@(posedge clock);
		while ((which ? ack2 : ack1) !== 1'b1) begin
			@(posedge clock);
		end
		rd = which ? rd2[7:0] : rd1[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		bus(1'b1, adr, d, tmp);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] adr, input logic [7:0] e);
		logic [7:0] g;
		bus(1'b0, adr, 8'h00, g);
		`CHK(nm, e, g)
	endtask : rdchk
	// ==========================================
	// Scenarios
	task automatic t_regs;
		wr(`PPC_OFF_DIR, 8'hFF);
		rdchk("data reset", `PPC_OFF_DATA, 8'h00);
		rdchk("unmapped", 8'h3C, 8'h00);
		rdchk("ps fixed", `PPC_OFF_PS, 8'hFF);
		wr(`PPC_OFF_DATA, 8'h5A);
		rdchk("data rw", `PPC_OFF_DATA, 8'h5A);
		wr(`PPC_OFF_DIR, 8'h00);
	endtask : t_regs
	task automatic t_irq;
		which = 1'b1;
		ext_en <= 8'hFF;
		wr(`PPC_OFF_PS, 8'h01);
		rdchk("ps writable", `PPC_OFF_PS, 8'h01);
		wr(`PPC_OFF_IE, 8'h03);
		wr(`PPC_OFF_MASK, 8'h01);
		bus(1'b0, `PPC_OFF_STAT, 8'h00, tmp);
		ext <= 8'h03;
		wt(6);
		`CHK("irq rise", 1'b1, irq2)
		rdchk("stat rise", `PPC_OFF_STAT, 8'h01);
		wt(2);
		`CHK("irq cleared", 1'b0, irq2)
		ext <= 8'h01;
		wt(6);
		`CHK("irq masked", 1'b0, irq2)
		rdchk("stat fall", `PPC_OFF_STAT, 8'h02);
		`CHK("first no irq", 1'b0, irq1)
		which = 1'b0;
	endtask : t_irq
	task automatic t_out;
		ext <= 8'h3C;
		wr(`PPC_OFF_DIR, 8'hF0);
		wr(`PPC_OFF_DATA, 8'hA5);
		wr(`PPC_OFF_RDR, 8'h30);
		wt(3);
		`CHK("oe", 8'hF0, pad1.oe)
		`CHK("out", 4'hA, pad1.out[7:4])
		`CHK("reduced", 2'h3, pad1.reduced[5:4])
		rdchk("data mix", `PPC_OFF_DATA, 8'hAC);
		rdchk("pin view", `PPC_OFF_PIN, 8'hAC);
		wr(`PPC_OFF_DIR, 8'h0F);
		wt(2);
		rdchk("data dir swap", `PPC_OFF_DATA, 8'h35);
	endtask : t_out
	task automatic t_pull;
		ext_en <= 8'h00;
		wr(`PPC_OFF_DIR, 8'h00);
		wr(`PPC_OFF_PE, 8'hFF);
		wt(3);
		`CHK("pull down", 8'hFF, pad1.pull_down)
		`CHK("pull up sel", 8'hFE, pad2.pull_up)
		rdchk("data pulled", `PPC_OFF_DATA, 8'h00);
		wr(`PPC_OFF_DIR, 8'hF0);
		wt(2);
		`CHK("pull out off", 8'h0F, pad1.pull_down)
	endtask : t_pull
	task automatic t_alt;
		ext_en <= 8'hFF;
		ext <= 8'h03;
		wr(`PPC_OFF_DIR, 8'h02);
		alt <= '{seg_en: 8'h08, seg_out: 8'h08, wkup_clk_en: 1'b1, wkup_clk_out: 1'b1,
			nmi_en: 1'b1, mirq_en: 1'b1};
		wt(5);
		`CHK("seg oe", 1'b0, pad1.oe[3])
		`CHK("seg sel", 1'b1, pad1.seg_sel[3])
		`CHK("seg in off", 1'b0, pad1.in_en[3])
		`CHK("nmi oe", 1'b0, pad1.oe[1])
		`CHK("nmi req", 1'b1, nmi1)
		`CHK("mirq req", 1'b1, mirq1)
		alt.seg_en <= 8'h00;
		wt(2);
		`CHK("wkup oe", 1'b1, pad1.oe[3])
		`CHK("wkup out", 1'b1, pad1.out[3])
		rdchk("eff dir", `PPC_OFF_EFFDIR, 8'h08);
		alt <= '0;
	endtask : t_alt
	// ==========================================
	// Sequence and verdict
	task automatic results;
		$display("Compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		wt(2);
		t_regs;
		t_irq;
		t_out;
		t_pull;
		t_alt;
		results;
	end
	// Tests need about 120 cycles; stop at 20000
	initial begin
		#200000;
		n_fail++;
		results;
	end
endmodule : ppc_top_test
